// >>> fault_sup_pkg.sv
// Package: constants and types for the bridge driver fault supervisor
`default_nettype none
package fault_sup_pkg;
   localparam int CLK_MHZ = 50;
   // Times in nanoseconds
   localparam int T_RESET_MIN_NS = 2000;
   localparam int T_NORESET_MAX_NS = 500;
   localparam int T_PROP_MAX_NS = 1000;
   localparam int T_OC_BLANK_NS = 1500;
   localparam int T_SC_FILT_NS = 12000;
   localparam int T_SC_FILT_OPT_NS = 6800;
   localparam int T_OV_FILT_NS = 48000;
   localparam int T_VC_UV_NS = 100;
   localparam int T_VC_OV_NS = 150;
   localparam int NS_PER_CLK = 1000 / CLK_MHZ;
   // Cycle counts: least times round up, longest times round down
   localparam int RESET_CYC = (T_RESET_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int NORESET_CYC = T_NORESET_MAX_NS / NS_PER_CLK;
   localparam int ENA_FILT_CYC = (NORESET_CYC + RESET_CYC) / 2;
   localparam int OC_BLANK_CYC = T_OC_BLANK_NS / NS_PER_CLK;
   localparam int SC_FILT_CYC = T_SC_FILT_NS / NS_PER_CLK;
   localparam int SC_FILT_OPT_CYC = T_SC_FILT_OPT_NS / NS_PER_CLK;
   localparam int OV_FILT_CYC = T_OV_FILT_NS / NS_PER_CLK;
   localparam int VC_UV_CYC = T_VC_UV_NS / NS_PER_CLK;
   localparam int VC_OV_CYC = T_VC_OV_NS / NS_PER_CLK;
   localparam int CNT_W = 16;
   // Diagnostic pin codes {a,b}
   localparam logic [1:0] DIAG_UV_VC = 2'h0;
   localparam logic [1:0] DIAG_OT_OV = 2'h1;
   localparam logic [1:0] DIAG_SC_OC = 2'h2;
   localparam logic [1:0] DIAG_NONE = 2'h3;
   typedef enum logic [2:0] {
      F_NONE, F_VCC, F_SHORT, F_UV, F_OV, F_OT_OC
   } fault_rank_t;
endpackage : fault_sup_pkg
`default_nettype wire

// >>> persist_if.sv
// Interface: persistence filter request and qualified result
`default_nettype none
interface persist_if;
   logic raw;
   logic [fault_sup_pkg::CNT_W-1:0] limit;
   logic qual;
   modport filt (input raw, input limit, output qual);
   modport user (output raw, output limit, input qual);
endinterface : persist_if
`default_nettype wire

// >>> persist_filter.sv
// Persistence filter: qual rises after raw held for limit cycles
`default_nettype none
module persist_filter (
   input wire logic clk,
   input wire logic rst_b,
   persist_if.filt pf
);
   logic [fault_sup_pkg::CNT_W-1:0] cnt_reg;
   logic qual_reg;

   always_ff @(posedge clk) begin
      if (!rst_b || !pf.raw) begin
         cnt_reg <= '0;
      end else if (cnt_reg < pf.limit) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !pf.raw) begin
         qual_reg <= 1'b0;
      end else if (cnt_reg + 1'b1 >= pf.limit) begin
         qual_reg <= 1'b1;
      end
   end

   assign pf.qual = qual_reg;
endmodule : persist_filter
`default_nettype wire

// >>> fault_supervisor.sv
// Top: fault ranking, latching, enable reset and diagnostic encoding
// Behaviour
// RULE1: Faults rank supply check, short, uv, ov, then ot and oc together.
// RULE2: Enable low for the reset time clears latches and forces gates off.
// RULE3: While disabled only undervoltage and overtemperature are shown.
// RULE4: The host holds enable low at least 2.0 us to clear latched errors.
// RULE5: An enable low of 0.5 us or less neither resets nor clears latches.
// RULE6: Output stages follow an enable change within 1.0 us.
// RULE7: After undervoltage clears, outputs follow inputs within 1.0 us.
// RULE8: Overcurrent is blanked 1.5 us before the warning shows.
// RULE9: A short must persist 12 us, or 6.8 us as option, before shutdown.
// RULE10: Short filtering integrates so low duty never trips, high duty does; the code restarts the count whenever the short input drops.
// RULE11: Overvoltage must persist 30 to 65 us before shutdown.
// RULE12: Supply check filters undervoltage 0.1 us, overvoltage 0.15 us.
// RULE13: The host drives enable rising edges within 2 us.
// RULE14: Diagnostic pins: LL uv/supply, LH ot/ov, HL short/oc, HH none.
// RULE15: Short, overvoltage, supply faults latch; uv restarts; ot, oc warn.
// RULE16: Diagnostic pins show the highest ranked active fault.
`default_nettype none
module fault_supervisor #(
   parameter bit SC_FAST_OPTION = 1'b0,
   parameter int OV_FILT_CYCLES = fault_sup_pkg::OV_FILT_CYC,
   parameter int SC_FILT_CYCLES = fault_sup_pkg::SC_FILT_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic driver_arm_input,
   input wire logic short_fault_detect,
   input wire logic oc_compare,
   input wire logic uv_detect,
   input wire logic ov_detect,
   input wire logic ot_detect,
   input wire logic vcc_under,
   input wire logic vcc_over,
   input wire logic [5:0] gate_cmd,
   output logic [5:0] gate_drive,
   output logic diag_out_a,
   output logic diag_out_b
);
   localparam logic [fault_sup_pkg::CNT_W-1:0] ARM_LIM =
      fault_sup_pkg::CNT_W'(fault_sup_pkg::ENA_FILT_CYC);
   localparam logic [fault_sup_pkg::CNT_W-1:0] OC_LIM =
      fault_sup_pkg::CNT_W'(fault_sup_pkg::OC_BLANK_CYC);
   localparam logic [fault_sup_pkg::CNT_W-1:0] SC_LIM = SC_FAST_OPTION ?
      fault_sup_pkg::CNT_W'(fault_sup_pkg::SC_FILT_OPT_CYC) :
      fault_sup_pkg::CNT_W'(SC_FILT_CYCLES);
   localparam logic [fault_sup_pkg::CNT_W-1:0] OV_LIM =
      fault_sup_pkg::CNT_W'(OV_FILT_CYCLES);
   localparam logic [fault_sup_pkg::CNT_W-1:0] VU_LIM =
      fault_sup_pkg::CNT_W'(fault_sup_pkg::VC_UV_CYC);
   localparam logic [fault_sup_pkg::CNT_W-1:0] VO_LIM =
      fault_sup_pkg::CNT_W'(fault_sup_pkg::VC_OV_CYC);

   // ---------------------------------------------------------------
   // Enable low-time qualification
   // ---------------------------------------------------------------
   logic [fault_sup_pkg::CNT_W-1:0] low_cnt_reg;
   logic clear_reg;
   logic armed_reg;

   // Low pulses up to the no-reset time never reach the clear point
   always_ff @(posedge clk) begin
      if (!rst_b || driver_arm_input) begin
         low_cnt_reg <= '0;
      end else if (low_cnt_reg < ARM_LIM) begin // [RULE5]
         low_cnt_reg <= low_cnt_reg + 1'b1;
      end
   end

   // Latch clear once the low time is long enough
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clear_reg <= 1'b1;
      end else begin
         clear_reg <= !driver_arm_input && (low_cnt_reg >= ARM_LIM); // [RULE2]
      end
   end

   // Output stage enable follows the pin within one cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         armed_reg <= 1'b0;
      end else begin
         armed_reg <= driver_arm_input; // [RULE6]
      end
   end

   // ---------------------------------------------------------------
   // Detector filters
   // ---------------------------------------------------------------
   persist_if oc_pf ();
   persist_if sc_pf ();
   persist_if ov_pf ();
   persist_if vu_pf ();
   persist_if vo_pf ();

   assign oc_pf.raw = oc_compare;
   assign oc_pf.limit = OC_LIM; // [RULE8]
   assign sc_pf.raw = short_fault_detect && !uv_detect;
   assign sc_pf.limit = SC_LIM; // [RULE9] [RULE10]
   assign ov_pf.raw = ov_detect;
   assign ov_pf.limit = OV_LIM; // [RULE11]
   // Supply check only while enable is high
   assign vu_pf.raw = vcc_under && driver_arm_input;
   assign vu_pf.limit = VU_LIM; // [RULE12]
   assign vo_pf.raw = vcc_over && driver_arm_input;
   assign vo_pf.limit = VO_LIM; // [RULE12]

   persist_filter oc_filt (.clk(clk), .rst_b(rst_b), .pf(oc_pf));
   persist_filter sc_filt (.clk(clk), .rst_b(rst_b), .pf(sc_pf));
   persist_filter ov_filt (.clk(clk), .rst_b(rst_b), .pf(ov_pf));
   persist_filter vu_filt (.clk(clk), .rst_b(rst_b), .pf(vu_pf));
   persist_filter vo_filt (.clk(clk), .rst_b(rst_b), .pf(vo_pf));

   // ---------------------------------------------------------------
   // Latched faults
   // ---------------------------------------------------------------
   logic sc_lat_reg;
   logic ov_lat_reg;
   logic vc_lat_reg;
   logic uv_reg;
   logic ot_reg;

   // Set wins over the enable clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sc_lat_reg <= 1'b0;
      end else if (sc_pf.qual) begin
         sc_lat_reg <= 1'b1; // [RULE15]
      end else if (clear_reg) begin
         sc_lat_reg <= 1'b0; // [RULE2]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ov_lat_reg <= 1'b0;
      end else if (ov_pf.qual) begin
         ov_lat_reg <= 1'b1; // [RULE15]
      end else if (clear_reg) begin
         ov_lat_reg <= 1'b0; // [RULE2]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vc_lat_reg <= 1'b0;
      end else if (vu_pf.qual || vo_pf.qual) begin
         vc_lat_reg <= 1'b1; // [RULE15]
      end else if (clear_reg) begin
         vc_lat_reg <= 1'b0; // [RULE2]
      end
   end

   // Undervoltage and overtemperature track their inputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         uv_reg <= 1'b0;
         ot_reg <= 1'b0;
      end else begin
         uv_reg <= uv_detect; // [RULE15]
         ot_reg <= ot_detect;
      end
   end

   // ---------------------------------------------------------------
   // Gate drive
   // ---------------------------------------------------------------
   logic gates_ok;
   assign gates_ok = armed_reg && !clear_reg && !sc_lat_reg && !ov_lat_reg
      && !vc_lat_reg && !uv_reg; // [RULE7] [RULE15]

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gate_drive <= '0;
      end else if (gates_ok) begin
         gate_drive <= gate_cmd; // [RULE6] [RULE7]
      end else begin
         gate_drive <= '0; // [RULE2]
      end
   end

   // ---------------------------------------------------------------
   // Priority and diagnostic encoding
   // ---------------------------------------------------------------
   fault_sup_pkg::fault_rank_t top_fault;
   logic [1:0] code;

   always_comb begin
      top_fault = fault_sup_pkg::F_NONE;
      if (!armed_reg) begin
         if (uv_reg) begin
            top_fault = fault_sup_pkg::F_UV; // [RULE3]
         end else if (ot_reg) begin
            top_fault = fault_sup_pkg::F_OT_OC; // [RULE3]
         end
      end else if (vc_lat_reg) begin
         top_fault = fault_sup_pkg::F_VCC; // [RULE1] [RULE16]
      end else if (sc_lat_reg) begin
         top_fault = fault_sup_pkg::F_SHORT;
      end else if (uv_reg) begin
         top_fault = fault_sup_pkg::F_UV;
      end else if (ov_lat_reg) begin
         top_fault = fault_sup_pkg::F_OV;
      end else if (ot_reg) begin
         top_fault = fault_sup_pkg::F_OT_OC;
      end else if (oc_pf.qual) begin
         top_fault = fault_sup_pkg::F_OT_OC;
      end
   end

   always_comb begin
      case (top_fault)
         fault_sup_pkg::F_VCC, fault_sup_pkg::F_UV: begin
            code = fault_sup_pkg::DIAG_UV_VC; // [RULE14]
         end
         fault_sup_pkg::F_OV: begin
            code = fault_sup_pkg::DIAG_OT_OV;
         end
         fault_sup_pkg::F_SHORT: begin
            code = fault_sup_pkg::DIAG_SC_OC;
         end
         fault_sup_pkg::F_OT_OC: begin
            code = ot_reg ? fault_sup_pkg::DIAG_OT_OV :
               fault_sup_pkg::DIAG_SC_OC;
         end
         default: begin
            code = fault_sup_pkg::DIAG_NONE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         diag_out_a <= 1'b1;
         diag_out_b <= 1'b1;
      end else begin
         diag_out_a <= code[1]; // [RULE14] [RULE16]
         diag_out_b <= code[0];
      end
   end
endmodule : fault_supervisor
`default_nettype wire

// >>> fault_sup_sva.sv
// Checker: port-level assertions for the fault supervisor
`default_nettype none
module fault_sup_sva #(
   parameter int SC_FILT_CYCLES = fault_sup_pkg::SC_FILT_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic driver_arm_input,
   input wire logic short_fault_detect,
   input wire logic oc_compare,
   input wire logic uv_detect,
   input wire logic ov_detect,
   input wire logic ot_detect,
   input wire logic vcc_under,
   input wire logic vcc_over,
   input wire logic [5:0] gate_cmd,
   input wire logic [5:0] gate_drive,
   input wire logic diag_out_a,
   input wire logic diag_out_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sc_run_reg;
   wire logic [1:0] diag = {diag_out_a, diag_out_b};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Armed short run length, uv suspends short sensing
   always_ff @(posedge clk) begin
      if (!rst_b || !short_fault_detect || !driver_arm_input || uv_detect) begin
         sc_run_reg <= 16'h0000;
      end else if (sc_run_reg != 16'hffff) begin
         sc_run_reg <= sc_run_reg + 16'h0001;
      end
   end
   gates_off_a:
      assert property (!driver_arm_input [*3] |-> gate_drive == 6'h00)
      else $error("gates on while disabled");
   disabled_diag_a:
      assert property (!driver_arm_input [*3] |-> diag != 2'h2)
      else $error("short code shown while disabled");
   short_trip_a:
      assert property (sc_run_reg == 16'(SC_FILT_CYCLES + 3)
         |-> gate_drive == 6'h00)
      else $error("short not shut down after filter");
   oc_blank_a:
      assert property (driver_arm_input [*3] ##0 ($rose(oc_compare)
         && diag == 2'h3 && !short_fault_detect) |-> ##1 (diag != 2'h2) [*8])
      else $error("overcurrent shown inside blanking");
   uv_shut_a:
      assert property (uv_detect [*3] |-> gate_drive == 6'h00 && diag != 2'h3)
      else $error("undervoltage not shut down");
   ot_shown_a:
      assert property (ot_detect [*3] |-> diag != 2'h3)
      else $error("overtemperature not shown");
   vcc_latch_a:
      assert property ((driver_arm_input && vcc_under) [*8] ##1
         driver_arm_input [*2] |-> diag == 2'h0)
      else $error("supply fault not latched");
   gate_follow_a:
      assert property ((driver_arm_input && !uv_detect && diag == 2'h3) [*4]
         ##0 $stable(gate_cmd) && gate_cmd == $past(gate_cmd, 2)
         |-> gate_drive == gate_cmd)
      else $error("gates not following command");
endmodule : fault_sup_sva
bind fault_supervisor fault_sup_sva #(.SC_FILT_CYCLES(SC_FILT_CYCLES)) chk_u (
   .clk(clk), .rst_b(rst_b), .driver_arm_input(driver_arm_input),
   .short_fault_detect(short_fault_detect), .oc_compare(oc_compare),
   .uv_detect(uv_detect), .ov_detect(ov_detect), .ot_detect(ot_detect),
   .vcc_under(vcc_under), .vcc_over(vcc_over), .gate_cmd(gate_cmd),
   .gate_drive(gate_drive), .diag_out_a(diag_out_a), .diag_out_b(diag_out_b)
);
`default_nettype wire

// >>> host_model.sv
// Host model: drives the arm input as a controller would
`default_nettype none
module host_model (
   input wire logic clk,
   output logic driver_arm_input
);
   timeunit 1ns;
   timeprecision 1ps;
   initial driver_arm_input = 1'b0;
   // Clean one-step level change
   task automatic set_arm(input logic v);
      @(posedge clk);
      driver_arm_input <= v;
   endtask : set_arm
   task automatic glitch(input int n);
      set_arm(1'b0);
      repeat (n) @(posedge clk);
      driver_arm_input <= 1'b1;
   endtask : glitch
   // Low for the full clear time
   task automatic clear_errors();
      glitch(fault_sup_pkg::RESET_CYC);
   endtask : clear_errors
endmodule : host_model
`default_nettype wire

// >>> fault_supervisor_tb.sv
// Testbench: fault supervisor scenarios with queued expectations
`default_nettype none
module fault_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic arm;
   logic sc = 1'b0, oc = 1'b0, uv = 1'b0, ov = 1'b0, ot = 1'b0;
   logic vu = 1'b0, vo = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic [5:0] gate;
   logic da, db;
   logic [31:0] seed = 32'h66ae_a896;
   logic [7:0] exp_q[$];
   // {uv,ot,oc,code} and {short,ov,vu,vo,code}
   logic [4:0] warn_tab[4] = '{5'h1c, 5'h0d, 5'h06, 5'h10};
   logic [5:0] latch_tab[5] = '{6'h11, 6'h08, 6'h04, 6'h32, 6'h28};
   event note_ev;
   int errors = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   host_model host_u (.clk(clk), .driver_arm_input(arm));
   fault_supervisor #(.OV_FILT_CYCLES(20), .SC_FILT_CYCLES(20)) dut_u (
      .clk(clk), .rst_b(rst_b), .driver_arm_input(arm),
      .short_fault_detect(sc), .oc_compare(oc), .uv_detect(uv),
      .ov_detect(ov), .ot_detect(ot), .vcc_under(vu), .vcc_over(vo),
      .gate_cmd(cmd), .gate_drive(gate), .diag_out_a(da), .diag_out_b(db)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic note(input logic [7:0] e);
      exp_q.push_back(e);
      -> note_ev;
   endtask : note
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic print_verdict();
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   always begin
      @(note_ev);
      @(negedge clk);
      check({da, db, gate}, exp_q.pop_front());
   end
   initial begin
      cyc(20000);
      errors++;
      print_verdict();
   end
   initial begin
      cyc(3);
      rst_b <= 1'b1;
      host_u.set_arm(1'b1);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         cmd <= 6'h01 << (seed % 6);
         cyc(10);
         note({2'h3, cmd});
      end
      // Short bursts shorter than the filter never trip
      repeat (8) begin
         sc <= 1'b1;
         cyc(15);
         sc <= 1'b0;
         cyc(5);
      end
      note({2'h3, cmd});
      sc <= 1'b1;
      cyc(30);
      sc <= 1'b0;
      cyc(5);
      note({2'h2, 6'h00});
      host_u.glitch(fault_sup_pkg::NORESET_CYC);
      cyc(10);
      note({2'h2, 6'h00});
      host_u.set_arm(1'b0);
      ot <= 1'b1;
      cyc(5);
      note({2'h1, 6'h00});
      ot <= 1'b0;
      cyc(5);
      note({2'h3, 6'h00});
      host_u.clear_errors();
      cyc(10);
      note({2'h3, cmd});
      foreach (warn_tab[i]) begin
         {uv, ot, oc} <= warn_tab[i][4:2];
         cyc(90);
         note({warn_tab[i][1:0], uv ? 6'h00 : cmd});
         {uv, ot, oc} <= 3'h0;
         cyc(5);
         note({2'h3, cmd});
      end
      foreach (latch_tab[i]) begin
         {sc, ov, vu, vo} <= latch_tab[i][5:2];
         cyc(30);
         {sc, ov, vu, vo} <= 4'h0;
         cyc(5);
         note({latch_tab[i][1:0], 6'h00});
         host_u.clear_errors();
         cyc(10);
         note({2'h3, cmd});
      end
      cyc(2);
      print_verdict();
   end
endmodule : fault_supervisor_tb
`default_nettype wire
